//--- verilog/tmr56_regs.svh
// Register offsets, field positions and reset values for the timer control
`ifndef TMR56_REGS_SVH
`define TMR56_REGS_SVH

`define T5_CONTROL_ADDR     6'h20
`define T6_CONTROL_ADDR     6'h21
`define T5_PERIOD_ADDR      6'h22
`define T5_PULSE_ADDR       6'h23
`define T6_PERIOD_ADDR      6'h24
`define T6_PULSE_ADDR       6'h25
`define PRESCALE_ADDR       6'h26
`define STATUS_ADDR         6'h27

`define CTRL_PRESET_BIT     7
`define CTRL_CLOCK_HI       6
`define CTRL_CLOCK_LO       4
`define CTRL_RUN_BIT        3
`define CTRL_MODE_HI        2
`define CTRL_MODE_LO        0

`define CTRL_RESET          8'h00
`define TREG_RESET          8'h00
`define PRESCALE_RESET      8'h00
`define PRESCALER_WIDTH     13

`endif

//--- verilog/tmr56_pkg.sv
// Types shared by the timer control block
`default_nettype none
package tmr56_pkg;
    typedef enum logic [3:0] {
        MODE5_TIMER   = 4'b0001,
        MODE5_DIVIDER = 4'b0010,
        MODE5_PWM     = 4'b0100,
        MODE5_CASCADE = 4'b1000
    } mode5_e;

    typedef logic [7:0] byte_t;
endpackage : tmr56_pkg
`default_nettype wire

//--- verilog/tmr56_regfile.sv
// Small memory holding the four 8-bit timer registers
`include "tmr56_regs.svh"
`default_nettype none
module tmr56_regfile
    import tmr56_pkg::*;
#(
    parameter int DEPTH = 4
) (
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     we_i,
    input  wire logic [$clog2(DEPTH)-1:0] waddr_i,
    input  wire logic [7:0]               wdata_i,
    input  wire logic [$clog2(DEPTH)-1:0] raddr_i,
    output logic      [7:0]               rdata_o,
    output logic      [DEPTH*8-1:0]       all_o
);
    logic [7:0] mem      [DEPTH];
    logic [7:0] next_mem [DEPTH];
    logic [7:0] next_rdata;

    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            next_mem[i] = mem[i];
        end
        if (we_i) begin
            next_mem[waddr_i] = wdata_i;
        end
        next_rdata = mem[raddr_i];
    end

    always_ff @(posedge clk_i) begin
        for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= rst_i ? `TREG_RESET : next_mem[i];
        end
        rdata_o <= rst_i ? 8'h00 : next_rdata;
    end

    generate
        for (genvar g = 0; g < DEPTH; g++) begin : g_flat
            assign all_o[g*8 +: 8] = mem[g];
        end
    endgenerate
endmodule : tmr56_regfile
`default_nettype wire

//--- verilog/tmr56_prescaler.sv
// Free-running prescaler giving one-cycle count enables
`include "tmr56_regs.svh"
`default_nettype none
module tmr56_prescaler
    import tmr56_pkg::*;
#(
    parameter int WIDTH = `PRESCALER_WIDTH
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    output logic      [WIDTH-1:0] tap_o
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;

    always_comb begin
        next_count = count + {{(WIDTH-1){1'b0}}, 1'b1};
    end

    always_ff @(posedge clk_i) begin
        count <= rst_i ? '0 : next_count;
    end

    // Tap k pulses once every 2^(k+1) cycles
    always_ff @(posedge clk_i) begin
        tap_o <= rst_i ? '0 : (next_count & ~count);
    end
endmodule : tmr56_prescaler
`default_nettype wire

//--- verilog/tmr56_control.sv
// Control and configuration of the cascadable 8-bit timers 5 and 6
//
// Contract
// - Unit-5 control: 8 bits at 0x20, reset zero
// - Each unit: control, period, pulse-width registers
// - Clock select picks prescaler tap or pin
// - Mode field: timer, divider, PWM, cascade
// - Cascade clock from unit-5 clock select
// - Cascade run and preset follow unit 6
// - Run 0 halts and clears; 1 starts
`include "tmr56_regs.svh"
`default_nettype none
module tmr56_control
    import tmr56_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic        timer5_event_pin_i,
    output logic             count5_en_o,
    output logic             count6_en_o,
    output logic             timer5_running_o,
    output logic             timer6_running_o,
    output logic             counter_clear_o,
    output logic             timer5_flop_o,
    output logic             timer6_flop_o,
    output logic [3:0]       timer5_mode_o,
    output logic             cascade_o,
    output logic [7:0]       timer5_period_o,
    output logic [7:0]       timer5_pulse_width_o,
    output logic [7:0]       timer6_period_o,
    output logic [7:0]       timer6_pulse_width_o
);
    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    function automatic logic [2:0] clock_field(input logic [7:0] c);
        clock_field = c[`CTRL_CLOCK_HI:`CTRL_CLOCK_LO];
    endfunction : clock_field

    function automatic logic [2:0] mode_field(input logic [7:0] c);
        mode_field = c[`CTRL_MODE_HI:`CTRL_MODE_LO];
    endfunction : mode_field

    function automatic byte_t treg_byte(input logic [31:0] all,
                                        input logic [1:0]  idx);
        treg_byte = all[idx*8 +: 8];
    endfunction : treg_byte

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    byte_t       timer5_control;
    byte_t       timer6_control;
    logic        prescaler_halving_select;
    byte_t       next_timer5_control;
    byte_t       next_timer6_control;
    logic        next_halving;
    logic        next_ack;
    logic [31:0] next_dat;
    logic        treg_we;
    logic [1:0]  treg_waddr;
    logic [1:0]  treg_raddr;
    logic [31:0] treg_all;
    logic        is_treg;
    logic        req;
    logic [5:0]  word;

    assign req  = cyc_i && stb_i && !ack_o;
    assign word = adr_i[7:2];

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    always_comb begin
        next_timer5_control = timer5_control;
        next_timer6_control = timer6_control;
        next_halving        = prescaler_halving_select;
        next_ack            = req;
        next_dat            = 32'h0000_0000;
        treg_we             = 1'b0;
        treg_waddr          = 2'h0;
        is_treg             = 1'b0;
        if (word == `T5_CONTROL_ADDR) begin
            next_dat = {24'h00_0000, timer5_control};
            if (req && we_i && sel_i[0]) begin
                next_timer5_control = dat_i[7:0];
            end
        end else if (word == `T6_CONTROL_ADDR) begin
            next_dat = {24'h00_0000, timer6_control};
            if (req && we_i && sel_i[0]) begin
                next_timer6_control = dat_i[7:0];
            end
        end else if (word == `T5_PERIOD_ADDR) begin
            is_treg    = 1'b1;
            treg_waddr = 2'h0;
            next_dat   = {24'h00_0000, treg_byte(treg_all, 2'h0)};
        end else if (word == `T5_PULSE_ADDR) begin
            is_treg    = 1'b1;
            treg_waddr = 2'h1;
            next_dat   = {24'h00_0000, treg_byte(treg_all, 2'h1)};
        end else if (word == `T6_PERIOD_ADDR) begin
            is_treg    = 1'b1;
            treg_waddr = 2'h2;
            next_dat   = {24'h00_0000, treg_byte(treg_all, 2'h2)};
        end else if (word == `T6_PULSE_ADDR) begin
            is_treg    = 1'b1;
            treg_waddr = 2'h3;
            next_dat   = {24'h00_0000, treg_byte(treg_all, 2'h3)};
        end else if (word == `PRESCALE_ADDR) begin
            next_dat = {31'h0000_0000, prescaler_halving_select};
            if (req && we_i && sel_i[0]) begin
                next_halving = dat_i[0];
            end
        end else if (word == `STATUS_ADDR) begin
            next_dat = {30'h0000_0000, timer6_running_o,
                        timer5_running_o};
        end else begin
            next_dat = 32'h0000_0000;
        end
        if (is_treg) begin
            treg_we      = req && we_i && sel_i[0];
        end
        if (!req || we_i) begin
            next_dat = 32'h0000_0000;
        end
    end

    assign treg_raddr = treg_waddr;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer5_control           <= `CTRL_RESET;
            timer6_control           <= `CTRL_RESET;
            prescaler_halving_select <= 1'b0;
            ack_o                    <= 1'b0;
        end else begin
            timer5_control           <= next_timer5_control;
            timer6_control           <= next_timer6_control;
            prescaler_halving_select <= next_halving;
            ack_o                    <= next_ack;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Registered so read data stands with ack only
    always_ff @(posedge clk_i) begin
        dat_o <= rst_i ? 32'h0000_0000 : next_dat;
    end

    // ------------------------------------------------------------
    // Timer register memory
    // ------------------------------------------------------------
    tmr56_regfile #(
        .DEPTH (4)
    ) u_regfile (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .we_i    (treg_we),
        .waddr_i (treg_waddr),
        .wdata_i (dat_i[7:0]),
        .raddr_i (treg_raddr),
        .rdata_o (),
        .all_o   (treg_all)
    );

    // ------------------------------------------------------------
    // Source clock selection
    // ------------------------------------------------------------
    logic [`PRESCALER_WIDTH-1:0] tap;
    logic                        pin_q;
    logic                        pin_edge;
    logic                        next_pin_edge;

    tmr56_prescaler #(
        .WIDTH (`PRESCALER_WIDTH)
    ) u_prescaler (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .tap_o (tap)
    );

    // ------------------------------------------------------------
    // Event pin edge
    // ------------------------------------------------------------

    always_comb begin
        next_pin_edge = timer5_event_pin_i && !pin_q;
    end

    always_ff @(posedge clk_i) begin
        pin_q    <= rst_i ? 1'b0 : timer5_event_pin_i;
        pin_edge <= rst_i ? 1'b0 : next_pin_edge;
    end

    // Tap k is fc/2^(k+1); halving adds one more stage
    function automatic logic pick_source(input logic [2:0] sel,
                                         input logic       halve);
        logic [3:0] base;
        base = 4'h0;
        pick_source = 1'b0;
        case (sel)
            3'b000: base = 4'ha;
            3'b001: base = 4'h6;
            3'b010: base = 4'h4;
            3'b011: base = 4'h2;
            default: base = 4'h0;
        endcase
        if (sel == 3'b111) begin
            pick_source = pin_edge;
        end else if (sel[2] == 1'b0) begin
            pick_source = tap[base + {3'h0, halve}];
        end
    endfunction : pick_source

    // ------------------------------------------------------------
    // Mode, run and cascade
    // ------------------------------------------------------------
    logic   cascade;
    logic   run5;
    logic   run6;
    logic   next_clear;
    logic   src5;
    logic   src6;
    mode5_e mode5;

    always_comb begin
        case (mode_field(timer5_control))
            3'b000:  mode5 = MODE5_TIMER;
            3'b001:  mode5 = MODE5_DIVIDER;
            3'b010:  mode5 = MODE5_PWM;
            3'b011:  mode5 = MODE5_CASCADE;
            default: mode5 = MODE5_TIMER;
        endcase
        cascade = (mode5 == MODE5_CASCADE);
        run6    = timer6_control[`CTRL_RUN_BIT];
        run5    = cascade ? run6 : timer5_control[`CTRL_RUN_BIT];
        src5    = pick_source(clock_field(timer5_control),
                              prescaler_halving_select);
        src6    = cascade ? src5
                : pick_source(clock_field(timer6_control),
                              prescaler_halving_select);
        next_clear = (!run5 && timer5_running_o)
                  || (!run6 && timer6_running_o);
    end

    // ------------------------------------------------------------
    // Control outputs
    // ------------------------------------------------------------

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count5_en_o          <= 1'b0;
            count6_en_o          <= 1'b0;
            timer5_running_o     <= 1'b0;
            timer6_running_o     <= 1'b0;
            counter_clear_o      <= 1'b0;
            timer5_flop_o        <= 1'b0;
            timer6_flop_o        <= 1'b0;
            timer5_mode_o        <= MODE5_TIMER;
            cascade_o            <= 1'b0;
        end else begin
            count5_en_o      <= run5 && src5;
            count6_en_o      <= run6 && src6;
            timer5_running_o <= run5;
            timer6_running_o <= run6;
            counter_clear_o  <= next_clear;
            timer5_flop_o    <= cascade
                ? timer6_control[`CTRL_PRESET_BIT]
                : timer5_control[`CTRL_PRESET_BIT];
            timer6_flop_o    <= timer6_control[`CTRL_PRESET_BIT];
            timer5_mode_o    <= mode5;
            cascade_o        <= cascade;
        end
    end

    // ------------------------------------------------------------
    // Timer register copies
    // ------------------------------------------------------------
    // Software no hardware lock applied
    always_ff @(posedge clk_i) begin
        timer5_period_o      <= rst_i ? 8'h00 : treg_all[7:0];
        timer5_pulse_width_o <= rst_i ? 8'h00 : treg_all[15:8];
        timer6_period_o      <= rst_i ? 8'h00 : treg_all[23:16];
        timer6_pulse_width_o <= rst_i ? 8'h00 : treg_all[31:24];
    end
endmodule : tmr56_control
`default_nettype wire

//--- verification/cpu_bus_model.sv
// Bus master model standing in for the CPU software
`default_nettype none
module cpu_bus_model (
    input  wire logic        clk_i,
    input  wire logic        go_i,
    input  wire logic        wr_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic [3:0]  bsel_i,
    input  wire logic        ack_i,
    input  wire logic [31:0] rdat_i,
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic      [7:0]  adr_o,
    output logic      [3:0]  sel_o,
    output logic      [31:0] dat_o,
    output logic      [31:0] rdata_o,
    output logic             done_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o, rdata_o, done_o} = '0;
    end
    // Request held until ack, released data inverted
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        if (cyc_o && ack_i) begin
            rdata_o <= rdat_i;
            {cyc_o, stb_o, we_o} <= 3'b000;
            dat_o   <= ~dat_o;
            done_o  <= 1'b1;
        end else if (go_i && !cyc_o) begin
            {cyc_o, stb_o, we_o} <= {2'b11, wr_i};
            adr_o <= addr_i;
            sel_o <= bsel_i;
            dat_o <= {24'h000000, wdata_i};
        end
    end
endmodule : cpu_bus_model
`default_nettype wire

//--- verification/tmr56_control_sva.sv
// Checker for the timer control block ports
`default_nettype none
module tmr56_control_sva (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic [31:0] dat_o,
    input  wire logic        ack_o,
    input  wire logic        timer5_running_o,
    input  wire logic        timer6_running_o,
    input  wire logic        counter_clear_o,
    input  wire logic        timer5_flop_o,
    input  wire logic        timer6_flop_o,
    input  wire logic [3:0]  timer5_mode_o,
    input  wire logic        cascade_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_follows: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("no ack after request");
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    a_read_width: assert property (ack_o |-> dat_o[31:8] == 24'h000000)
        else $error("read data wider than 8 bits");
    a_idle_zero: assert property (!ack_o |-> dat_o == 32'h00000000)
        else $error("read data outside ack");
    a_mode_onehot: assert property ($onehot(timer5_mode_o))
        else $error("mode output not one-hot");
    a_cascade_run: assert property (cascade_o |->
        timer5_running_o == timer6_running_o)
        else $error("cascade run not from unit 6");
    a_cascade_flop: assert property (cascade_o |->
        timer5_flop_o == timer6_flop_o)
        else $error("cascade preset not from unit 6");
    a_clear_stop: assert property ($fell(timer5_running_o) |->
        ##[0:1] counter_clear_o)
        else $error("no counter clear on stop");
endmodule : tmr56_control_sva
bind tmr56_control tmr56_control_sva u_sva (.clk_i, .rst_i, .cyc_i, .stb_i,
    .dat_o, .ack_o, .timer5_running_o, .timer6_running_o, .counter_clear_o,
    .timer5_flop_o, .timer6_flop_o, .timer5_mode_o, .cascade_o);
`default_nettype wire

//--- verification/tmr56_control_tb.sv
// Self-checking bench for the timer control block
`default_nettype none
module tmr56_control_tb;
    import tmr56_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 0, rst_i = 1, pin = 0, go = 0, wr = 0;
    logic [7:0]  a = 0, d = 0;
    logic [3:0]  s = 4'hf;
    logic        cyc, stb, we, ack, done, c5, c6, r5, r6, clr, f5, f6, cas;
    logic [7:0]  adr, p5, w5, p6, w6;
    logic [3:0]  sel, m5;
    logic [31:0] wdat, rdat, got;
    int          n_mismatch = 0, total_checks = 0, n5 = 0;
    initial forever #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) if (c5) n5 <= n5 + 1;
    cpu_bus_model cpu (.clk_i, .go_i(go), .wr_i(wr), .addr_i(a), .wdata_i(d),
        .bsel_i(s), .ack_i(ack), .rdat_i(rdat), .cyc_o(cyc), .stb_o(stb),
        .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat), .rdata_o(got),
        .done_o(done));
    tmr56_control DUT (.clk_i, .rst_i, .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .timer5_event_pin_i(pin), .count5_en_o(c5), .count6_en_o(c6),
        .timer5_running_o(r5), .timer6_running_o(r6), .counter_clear_o(clr),
        .timer5_flop_o(f5), .timer6_flop_o(f6), .timer5_mode_o(m5),
        .cascade_o(cas), .timer5_period_o(p5), .timer5_pulse_width_o(w5),
        .timer6_period_o(p6), .timer6_pulse_width_o(w6));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] ad,
                       input logic [7:0] da, input logic [3:0] bs);
        int n;
        {wr, a, d, s} <= {w, ad, da, bs};
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        n = 0;
        while (!done && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        if (n == 50) begin
            n_mismatch++;
            $display("[ERR] %0t no ack got %h exp %h", $time, done, 1'b1);
        end
        repeat (3) @(posedge clk_i);
    endtask : bus
    task automatic gap(input int e, input bit six = 1'b0);
        int n;
        n = 0;
        while (!(six ? c6 : c5) && n < 9000) begin
            @(posedge clk_i);
            n++;
        end
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (!(six ? c6 : c5) && n < 9000);
        chk(n, e);
    endtask : gap
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        for (int i = 0; i < 5; i++) begin
            bus(0, 8'h80 + 8'(4 * 2 * (i > 0) + 4 * (i > 0 ? i - 1 : 0)),
                8'h00, 4'hf);
            chk(got, 32'h0);
        end
        chk(m5, 4'b0001);
    endtask : t_reset
    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            bus(1, 8'h80, {4'b1011, 1'b1, 3'(m)}, 4'hf);
            chk(m5, 32'h1 << m);
            chk(cas, m == 3);
            chk({r5, f5}, m == 3 ? 2'b00 : 2'b11);
            bus(0, 8'h80, 8'h00, 4'hf);
            chk(got, {4'b1011, 1'b1, 3'(m)});
            bus(1, 8'h80, {4'b1011, 1'b0, 3'(m)}, 4'hf);
            chk(r5, 1'b0);
        end
    endtask : t_modes
    task automatic t_regs();
        for (int i = 0; i < 4; i++) begin
            bus(1, 8'h88 + 8'(4 * i), 8'h5a ^ 8'(i), 4'hf);
            bus(1, 8'h88 + 8'(4 * i), 8'hff, 4'he);
            bus(0, 8'h88 + 8'(4 * i), 8'h00, 4'hf);
            chk(got, 8'h5a ^ 8'(i));
        end
        chk({p5, w5, p6, w6}, 32'h5a5b5859);
        bus(1, 8'ha0, 8'hff, 4'hf);
        bus(0, 8'ha0, 8'h00, 4'hf);
        chk(got, 32'h0);
    endtask : t_regs
    task automatic t_clock();
        int sh[4] = '{11, 7, 5, 3};
        for (int h = 0; h < 2; h++) begin
            bus(1, 8'h98, 8'(h), 4'hf);
            for (int c = 0; c < 4; c++) begin
                bus(1, 8'h80, {1'b0, 3'(c), 4'b1000}, 4'hf);
                gap(1 << (sh[c] + h));
                bus(1, 8'h80, {1'b0, 3'(c), 4'b0000}, 4'hf);
            end
        end
        bus(1, 8'h98, 8'h00, 4'hf);
    endtask : t_clock
    task automatic t_pin();
        int base;
        bus(1, 8'h80, 8'h68, 4'hf);
        base = n5;
        repeat (300) @(posedge clk_i);
        chk(n5 - base, 0);
        bus(1, 8'h80, 8'h60, 4'hf);
        bus(1, 8'h80, 8'h78, 4'hf);
        base = n5;
        repeat (3) begin
            pin <= 1'b1;
            repeat (6) @(posedge clk_i);
            pin <= 1'b0;
            repeat (6) @(posedge clk_i);
        end
        chk(n5 - base, 3);
        bus(1, 8'h80, 8'h70, 4'hf);
    endtask : t_pin
    task automatic t_cascade();
        bus(1, 8'h80, 8'h33, 4'hf);
        bus(1, 8'h84, 8'h8c, 4'hf);
        chk({cas, r5, f5}, 3'b111);
        gap(8);
        gap(8, 1'b1);
        bus(1, 8'h84, 8'h84, 4'hf);
        chk({r5, r6, f6}, 3'b001);
    endtask : t_cascade
    initial begin
        repeat (60000) @(posedge clk_i);
        n_mismatch++;
        close_out();
    end
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_modes();
        t_regs();
        t_clock();
        t_pin();
        t_cascade();
        close_out();
    end
endmodule : tmr56_control_tb
`default_nettype wire
